// [rtl/standby_touch_consts.svh]
`ifndef STANDBY_TOUCH_CONSTS_SVH
`define STANDBY_TOUCH_CONSTS_SVH

// Register indices; byte address is four times the index
`define IDX_INPUT_MASK 8'h40
`define IDX_SAMPLING_CFG 8'h41
`define IDX_GAIN_SELECT 8'h42
`define IDX_TOUCH_THRESHOLD 8'h43
`define IDX_STANDBY_CTRL 8'h44
`define IDX_STANDBY_STATUS 8'h45
`define IDX_DELTA_BASE 8'h48

// Reset values
`define RST_INPUT_MASK 8'h00
`define RST_SAMPLING_CFG 8'h39
`define RST_GAIN_SELECT 3'h2
`define RST_TOUCH_THRESHOLD 7'h40
`define RST_STANDBY_CTRL 1'h0

// Sampling configuration fields
`define ACC_SEL_BIT 7
`define CNT_MSB 6
`define CNT_LSB 4
`define SPER_MSB 3
`define SPER_LSB 2
`define CPER_MSB 1
`define CPER_LSB 0

// Timing
`define CLK_MHZ 50
`define TICK_US 10
`define TICK_CYCLES (`TICK_US * `CLK_MHZ)
`define SAMP_TIME0_US 320
`define SAMP_TIME1_US 640
`define SAMP_TIME2_US 1280
`define SAMP_TIME3_US 2560
`define CYC_TIME0_MS 35
`define CYC_TIME1_MS 70
`define CYC_TIME2_MS 105
`define CYC_TIME3_MS 140

`endif

// [rtl/standby_touch_pkg.sv]
package standby_touch_pkg;
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_FINISH = 2'b11,
        ST_IDLE = 2'b10
    } scan_state_t;
endpackage : standby_touch_pkg

// [rtl/tick_divider.sv]
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
    parameter int TICK_CYCLES = 500
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic clear_in,
    output logic tick_out
);
    logic [15:0] cnt_r;
    wire wrap = (cnt_r == 16'(TICK_CYCLES - 1));

    // Cleared at cycle start so samples align to ticks
    assign tick_out = wrap && !clear_in;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || clear_in || wrap) begin
            cnt_r <= 16'h0000;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end
endmodule : tick_divider
`default_nettype wire

// [rtl/standby_touch_sensing.sv]
// Functional notes
// - Enabled inputs are measured in standby; disabled ones are not.
// - Mask bit n gates sense input n+1.
// - With accumulate select clear, the delta is the sample average.
// - With accumulate select set, the delta is the sample sum and may wrap.
// - The count field selects 1 to 128 samples as powers of two, reset 8.
// - All samples of one input run back to back before it is stored.
// - The sample period is 320us, 640us, 1.28ms or 2.56ms, reset 1.28ms.
// - The cycle period field selects 35ms, 70ms, 105ms or 140ms, reset 70ms.
// - Each cycle samples every enabled input first, then idles in low power.
// - If sampling overruns the cycle period, the cycle is lengthened.
// - The gain code selects a 128 over 2^code multiplier, reset 32x.
// - The multiplier scales each delta before the threshold compare.
// - The delta MSB weighs 64 raw counts at 128x and 8192 at 1x.
// - The threshold is seven bits, reset 40h, touch when delta exceeds it.
// - Standby settings affect only standby measurements.
`include "standby_touch_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module standby_touch_sensing #(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [9:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic [15:0] raw_delta_in,
    output logic [2:0] sense_select_out,
    output logic sample_start_out,
    output logic sampling_out,
    output logic low_power_out,
    output logic [7:0] touch_out
);
    // Samples per measurement
    // power-of-two count
    function automatic logic [7:0] samples_for(input logic [2:0] code);
        return 8'h01 << code;
    endfunction : samples_for

    function automatic logic [15:0] sample_ticks(input logic [1:0] code);
        logic [15:0] t;
        case (code)
            2'h0: t = 16'(`SAMP_TIME0_US / `TICK_US);
            2'h1: t = 16'(`SAMP_TIME1_US / `TICK_US);
            2'h2: t = 16'(`SAMP_TIME2_US / `TICK_US);
            default: t = 16'(`SAMP_TIME3_US / `TICK_US);
        endcase
        return t;
    endfunction : sample_ticks

    function automatic logic [15:0] cycle_ticks(input logic [1:0] code);
        logic [15:0] t;
        case (code)
            2'h0: t = 16'(`CYC_TIME0_MS * 1000 / `TICK_US);
            2'h1: t = 16'(`CYC_TIME1_MS * 1000 / `TICK_US);
            2'h2: t = 16'(`CYC_TIME2_MS * 1000 / `TICK_US);
            default: t = 16'(`CYC_TIME3_MS * 1000 / `TICK_US);
        endcase
        return t;
    endfunction : cycle_ticks

    // Lowest enabled input at or above from; 8 when none
    function automatic logic [3:0] next_input(input logic [7:0] mask,
                                              input logic [3:0] from);
        logic [3:0] r;
        r = 4'h8;
        for (int i = 7; i >= 0; i--) begin
            if (mask[i] && (4'(i) >= from)) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction : next_input

    // Combine samples and apply gain
    function automatic logic [7:0] scale_delta(input logic [22:0] sum,
                                               input logic [2:0] cnt,
                                               input logic accum,
                                               input logic [2:0] gain);
        logic [22:0] v;
        logic [23:0] s;
        v = sum >> cnt;
        if (accum) begin
            v = sum;
        end
        // MSB is 64 raw at 128x
        s = {v, 1'b0} >> gain;
        return s[7:0];
    endfunction : scale_delta

    // Registers
    logic [7:0] mask_r;
    logic [7:0] cfg_r;
    logic [2:0] gain_r;
    logic [6:0] thr_r;
    logic enable_r;
    logic ack_r;
    logic [31:0] dat_r;

    // Scan state
    standby_touch_pkg::scan_state_t state_r;
    standby_touch_pkg::scan_state_t state_nxt;
    logic [2:0] ch_r;
    logic [2:0] ch_nxt;
    logic [15:0] samp_tick_r;
    logic [6:0] samp_num_r;
    logic [22:0] acc_r;
    logic [15:0] cycle_cnt_r;
    logic [7:0] delta_r [8];
    logic [7:0] touch_r;
    logic start_r;
    logic start_nxt;
    logic tick;

    // Bus decode
    wire [7:0] idx = wb_adr_in[9:2];
    wire req = wb_cyc_in && wb_stb_in && !ack_r;
    wire wr_lane0 = req && wb_we_in && wb_sel_in[0];
    wire wr_mask = wr_lane0 && (idx == `IDX_INPUT_MASK);
    wire wr_cfg = wr_lane0 && (idx == `IDX_SAMPLING_CFG);
    wire wr_gain = wr_lane0 && (idx == `IDX_GAIN_SELECT);
    wire wr_thr = wr_lane0 && (idx == `IDX_TOUCH_THRESHOLD);
    wire wr_ctrl = wr_lane0 && (idx == `IDX_STANDBY_CTRL);
    wire is_delta = (idx[7:3] == `IDX_DELTA_BASE >> 3);

    // Config fields
    wire accum = cfg_r[`ACC_SEL_BIT];
    wire [2:0] cnt_code = cfg_r[`CNT_MSB:`CNT_LSB];
    wire [1:0] sper_code = cfg_r[`SPER_MSB:`SPER_LSB];
    wire [1:0] cper_code = cfg_r[`CPER_MSB:`CPER_LSB];

    // Scan decode
    wire [7:0] samp_limit = samples_for(cnt_code) - 8'h01;
    wire last_samp = ({1'b0, samp_num_r} == samp_limit);
    wire samp_end = tick && (state_r == standby_touch_pkg::ST_SAMPLE) &&
                    (samp_tick_r == sample_ticks(sper_code) - 16'h0001);
    // idle only until the period is reached
    wire cycle_done = (cycle_cnt_r >= cycle_ticks(cper_code));
    // new cycle after idle or on enable
    wire cycle_start = enable_r &&
        ((state_r == standby_touch_pkg::ST_OFF) ||
         ((state_r == standby_touch_pkg::ST_IDLE) && cycle_done));
    wire [3:0] first_ch = next_input(mask_r, 4'h0);
    wire [3:0] following_ch = next_input(mask_r, {1'b0, ch_r} + 4'h1);
    wire [7:0] scaled = scale_delta(acc_r, cnt_code, accum, gain_r);
    wire touched = scaled > {1'b0, thr_r};

    tick_divider #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .clear_in(cycle_start),
        .tick_out(tick)
    );

    always_comb begin
        state_nxt = state_r;
        ch_nxt = ch_r;
        start_nxt = 1'b0;
        case (state_r)
            standby_touch_pkg::ST_OFF,
            standby_touch_pkg::ST_IDLE: begin
                if (cycle_start) begin
                    if (first_ch[3]) begin
                        state_nxt = standby_touch_pkg::ST_IDLE;
                    end else begin
                        state_nxt = standby_touch_pkg::ST_SAMPLE;
                        ch_nxt = first_ch[2:0];
                        start_nxt = 1'b1;
                    end
                end
            end
            standby_touch_pkg::ST_SAMPLE: begin
                if (samp_end && last_samp) begin
                    state_nxt = standby_touch_pkg::ST_FINISH;
                end else if (samp_end) begin
                    start_nxt = 1'b1;
                end
            end
            standby_touch_pkg::ST_FINISH: begin
                if (following_ch[3]) begin
                    state_nxt = standby_touch_pkg::ST_IDLE;
                end else begin
                    state_nxt = standby_touch_pkg::ST_SAMPLE;
                    ch_nxt = following_ch[2:0];
                    start_nxt = 1'b1;
                end
            end
            default: begin
                state_nxt = standby_touch_pkg::ST_OFF;
            end
        endcase
        if (!enable_r) begin
            state_nxt = standby_touch_pkg::ST_OFF;
            start_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_r <= standby_touch_pkg::ST_OFF;
            ch_r <= 3'h0;
            start_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ch_r <= ch_nxt;
            start_r <= start_nxt;
        end
    end

    // Sample timing and accumulation
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || state_r != standby_touch_pkg::ST_SAMPLE) begin
            samp_tick_r <= 16'h0000;
            samp_num_r <= 7'h00;
        end else if (samp_end) begin
            samp_tick_r <= 16'h0000;
            samp_num_r <= samp_num_r + 7'h01;
        end else if (tick) begin
            samp_tick_r <= samp_tick_r + 16'h0001;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || state_r != standby_touch_pkg::ST_SAMPLE) begin
            acc_r <= 23'h000000;
        end else if (samp_end) begin
            acc_r <= acc_r + {7'h00, raw_delta_in};
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || cycle_start) begin
            cycle_cnt_r <= 16'h0000;
        end else if (tick && cycle_cnt_r != 16'hFFFF) begin
            cycle_cnt_r <= cycle_cnt_r + 16'h0001;
        end
    end

    // Results per input
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < 8; i++) begin
                delta_r[i] <= 8'h00;
            end
        end else if (state_r == standby_touch_pkg::ST_FINISH) begin
            delta_r[ch_r] <= scaled;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !enable_r) begin
            touch_r <= 8'h00;
        end else if (state_r == standby_touch_pkg::ST_FINISH) begin
            touch_r <= (touch_r & mask_r & ~(8'h01 << ch_r)) |
                       ({7'h00, touched} << ch_r);
        end else begin
            touch_r <= touch_r & mask_r;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            mask_r <= `RST_INPUT_MASK;
            cfg_r <= `RST_SAMPLING_CFG;
            gain_r <= `RST_GAIN_SELECT;
            thr_r <= `RST_TOUCH_THRESHOLD;
            enable_r <= `RST_STANDBY_CTRL;
        end else begin
            if (wr_mask) begin
                mask_r <= wb_dat_in[7:0];
            end
            if (wr_cfg) begin
                cfg_r <= wb_dat_in[7:0];
            end
            if (wr_gain) begin
                gain_r <= wb_dat_in[2:0];
            end
            if (wr_thr) begin
                thr_r <= wb_dat_in[6:0];
            end
            if (wr_ctrl) begin
                enable_r <= wb_dat_in[0];
            end
        end
    end

    // Read mux; unmapped reads zero
    logic [31:0] rd_data;
    always_comb begin
        rd_data = 32'h00000000;
        if (is_delta) begin
            rd_data = {24'h000000, delta_r[idx[2:0]]};
        end else begin
            case (idx)
                `IDX_INPUT_MASK: rd_data = {24'h000000, mask_r};
                `IDX_SAMPLING_CFG: rd_data = {24'h000000, cfg_r};
                `IDX_GAIN_SELECT: rd_data = {29'h00000000, gain_r};
                `IDX_TOUCH_THRESHOLD: rd_data = {25'h0000000, thr_r};
                `IDX_STANDBY_CTRL: rd_data = {31'h00000000, enable_r};
                `IDX_STANDBY_STATUS: rd_data = {22'h000000,
                    state_r == standby_touch_pkg::ST_SAMPLE,
                    state_r == standby_touch_pkg::ST_IDLE, touch_r};
                default: rd_data = 32'h00000000;
            endcase
        end
    end

    // One-cycle ack, dropped the cycle after
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ack_r <= 1'b0;
            dat_r <= 32'h00000000;
        end else begin
            ack_r <= req;
            if (req && !wb_we_in) begin
                dat_r <= rd_data;
            end
        end
    end

    assign wb_ack_out = ack_r;
    assign wb_dat_out = dat_r;
    assign sense_select_out = ch_r;
    assign sample_start_out = start_r;
    assign sampling_out = (state_r == standby_touch_pkg::ST_SAMPLE);
    assign low_power_out = (state_r == standby_touch_pkg::ST_IDLE);
    assign touch_out = touch_r;
endmodule : standby_touch_sensing
`default_nettype wire

// [verif/touch_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module touch_monitor (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_ack_out,
    input wire logic [2:0] sense_select_out,
    input wire logic sample_start_out,
    input wire logic sampling_out,
    input wire logic low_power_out,
    input wire logic [7:0] touch_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    a_ack_one_cycle: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack held longer than one cycle");
    a_ack_after_req: assert property
        (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("request not answered in one cycle");
    a_no_idle_ack: assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
        else $error("ack without request");
    a_sample_min_len: assert property (
        sample_start_out |=> !sample_start_out [*8])
        else $error("sample shorter than minimum");
    a_select_stable: assert property (
        sampling_out && $past(sampling_out) && !sample_start_out
        |-> $stable(sense_select_out))
        else $error("select moved inside a sample");
    a_idle_exclusive: assert property (low_power_out |-> !sampling_out)
        else $error("low power while sampling");
    a_start_in_sample: assert property (sample_start_out |-> sampling_out)
        else $error("start pulse outside sampling");
    // Reset must clear outputs even while held
    a_reset_clears: assert property (disable iff (1'b0)
        !rst_n_in |=> touch_out == 8'h00 && !sampling_out && !low_power_out)
        else $error("outputs not cleared by reset");
endmodule : touch_monitor
bind standby_touch_sensing touch_monitor u_touch_monitor (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out),
    .sense_select_out(sense_select_out),
    .sample_start_out(sample_start_out), .sampling_out(sampling_out),
    .low_power_out(low_power_out), .touch_out(touch_out));
`default_nettype wire

// [verif/pad_array_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pad_array_model (
    input wire logic clk_in,
    input wire logic [2:0] sense_select_in,
    input wire logic sampling_in,
    input wire logic [127:0] pad_levels_in,
    output logic [15:0] raw_delta_out
);
    // Outside a sample the level toggles so stale data is never reused
    always_ff @(posedge clk_in) begin
        if (sampling_in) begin
            raw_delta_out <= pad_levels_in[sense_select_in*16 +: 16];
        end else begin
            raw_delta_out <= ~raw_delta_out;
        end
    end
endmodule : pad_array_model
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct {logic [9:0] a; logic w; logic [31:0] d;} row_t;
    localparam int TICK = 2;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [9:0] adr = 10'h000;
    logic [31:0] wdat = 32'h0;
    logic [31:0] q;
    logic [31:0] dat_o;
    logic ack, start, smp, lp;
    logic lp_q = 1'b0;
    logic [15:0] raw;
    logic [2:0] sel;
    logic [7:0] touch;
    // Input 1 reads 100, input 3 reads 20, the rest full scale
    logic [127:0] pads = {{5{16'hFFFF}}, 16'h0014, 16'hFFFF, 16'h0064};
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    int n;
    logic [2:0] sel_q[$];
    int st_q[$];
    logic [11:0] ord;
    row_t rows [14] = '{'{10'h100, 1'b0, 32'h00}, '{10'h104, 1'b0, 32'h39},
        '{10'h108, 1'b0, 32'h02}, '{10'h10C, 1'b0, 32'h40},
        '{10'h108, 1'b1, 32'hFF}, '{10'h108, 1'b0, 32'h07},
        '{10'h10C, 1'b1, 32'hFF}, '{10'h10C, 1'b0, 32'h7F},
        '{10'h3FC, 1'b1, 32'h55}, '{10'h3FC, 1'b0, 32'h00},
        '{10'h100, 1'b1, 32'hA5}, '{10'h100, 1'b0, 32'hA5},
        '{10'h104, 1'b1, 32'hC6}, '{10'h104, 1'b0, 32'hC6}};

    standby_touch_sensing #(.TICK_CYCLES(TICK)) u_standby_touch_sensing (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF),
        .wb_dat_in(wdat), .wb_dat_out(dat_o), .wb_ack_out(ack),
        .raw_delta_in(raw), .sense_select_out(sel),
        .sample_start_out(start), .sampling_out(smp),
        .low_power_out(lp), .touch_out(touch));
    pad_array_model u_pad_array_model (.clk_in(clk_in),
        .sense_select_in(sel), .sampling_in(smp), .pad_levels_in(pads),
        .raw_delta_out(raw));

    initial begin
        forever #10 clk_in = ~clk_in;
    end

    task finish_test;
        if (mismatches == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task wb_xfer(input logic [9:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge clk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        k = 0;
        do begin
            @(posedge clk_in);
            k++;
        end while (ack !== 1'b1 && k < 40);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        chk("ack", 32'h1, {31'h0, ack});
    endtask : wb_xfer

    task rd(input logic [9:0] a, input logic [31:0] e);
        wb_xfer(a, 1'b0, 32'h0);
        chk($sformatf("reg %h", a), e, q);
    endtask : rd

    // Clocks from call to next rising edge of low power
    task wait_lp(output int c);
        c = 0;
        do begin
            @(posedge clk_in);
            c++;
        end while (!(lp === 1'b1 && lp_q === 1'b0));
    endtask : wait_lp

    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        lp_q <= lp;
        if (start === 1'b1) begin
            sel_q.push_back(sel);
            st_q.push_back(cycles);
        end
        // Whole run is about 72k clocks
        if (cycles == 90000) begin
            mismatches++;
            finish_test();
        end
    end

    initial begin
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        foreach (rows[i]) begin
            wb_xfer(rows[i].a, rows[i].w, rows[i].d);
            if (!rows[i].w) chk("row", rows[i].d, q);
        end
        wb_xfer(10'h108, 1'b1, 32'h00);
        wb_xfer(10'h10C, 1'b1, 32'h40);
        wb_xfer(10'h104, 1'b1, 32'h10);
        wb_xfer(10'h100, 1'b1, 32'h05);
        sel_q.delete();
        st_q.delete();
        wb_xfer(10'h110, 1'b1, 32'h01);
        wait_lp(n);
        ord = {sel_q[0], sel_q[1], sel_q[2], sel_q[3]};
        chk("starts", 32'd4, 32'(sel_q.size()));
        chk("order", 32'h012, {20'h0, ord});
        // 320us is 32 ticks of 10us
        chk("sample", 32'(32 * TICK), 32'(st_q[1] - st_q[0]));
        chk("touch", 32'h01, {24'h0, touch});
        // Back to back waits: rise to rise, 3500 ticks plus one clock
        wait_lp(n);
        chk("period", 32'h1, {31'h0, n >= 6997 && n <= 7003});
        rd(10'h120, 32'hC8);
        rd(10'h128, 32'h28);
        wb_xfer(10'h104, 1'b1, 32'h90);
        wait_lp(n);
        wait_lp(n);
        chk("touch", 32'h05, {24'h0, touch});
        rd(10'h120, 32'h90);
        wb_xfer(10'h100, 1'b1, 32'h04);
        wb_xfer(10'h114, 1'b0, 32'h0);
        chk("touch", 32'h04, {24'h0, q[7:0]});
        wb_xfer(10'h100, 1'b1, 32'h05);
        // 640us samples in a 70ms cycle
        wb_xfer(10'h104, 1'b1, 32'h15);
        wb_xfer(10'h108, 1'b1, 32'h07);
        st_q.delete();
        wait_lp(n);
        chk("sample", 32'(64 * TICK), 32'(st_q[1] - st_q[0]));
        wait_lp(n);
        chk("period", 32'h1, {31'h0, n >= 13997 && n <= 14005});
        chk("touch", 32'h00, {24'h0, touch});
        rd(10'h120, 32'h01);
        // Sixteen long samples overrun the shortest cycle
        wb_xfer(10'h100, 1'b1, 32'h01);
        wb_xfer(10'h104, 1'b1, 32'h4C);
        wait_lp(n);
        wait_lp(n);
        chk("overrun", 32'h1, {31'h0, n > 8192 && n < 8400});
        rst_n_in <= 1'b0;
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        chk("touch", 32'h00, {24'h0, touch});
        rd(10'h104, 32'h39);
        rd(10'h110, 32'h00);
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
